// file: audio_clock_params.svh
/*
 * Constants for the field-locked audio clock generator: register indexes,
 * field positions, widths and reset values.
 * Assumes inclusion by bare name from the design file and the bench.
 */
`ifndef AUDIO_CLOCK_PARAMS_SVH
`define AUDIO_CLOCK_PARAMS_SVH

// register indexes; byte address is four times the index
`define ACG_IDX_CPF_LO    6'h30
`define ACG_IDX_CPF_MID   6'h31
`define ACG_IDX_CPF_HI    6'h32
`define ACG_IDX_NI_LO     6'h34
`define ACG_IDX_NI_MID    6'h35
`define ACG_IDX_NI_HI     6'h36
`define ACG_IDX_BDIV      6'h38
`define ACG_IDX_LR_DIV    6'h39
`define ACG_IDX_PHASE     6'h3A
`define ACG_IDX_STATUS    6'h3B

// field masks of the byte registers
`define ACG_CPF_HI_MASK   8'h03
`define ACG_NI_HI_MASK    8'h3F
`define ACG_DIV_MASK      8'h3F
`define ACG_PHASE_MASK    8'h1B

// bit positions in the phase/control register
`define ACG_BIT_BPH       0
`define ACG_BIT_LR_PHASE  1
`define ACG_BIT_PLL_OPEN  3
`define ACG_BIT_XFWD_EN   4

// bit positions in the status register
`define ACG_BIT_XTAL_SEL  0
`define ACG_BIT_CORR_SAT  1

`define ACG_ACC_W         23
`define ACG_CORR_W        12
`define ACG_CPF_W         18
`define ACG_NI_W          22
`define ACG_RESET_BYTE    8'h00
`define ACG_CORR_MAX      12'h7FF
`define ACG_CORR_MIN      12'h800

`endif

// file: audio_clock_pkg.sv
/*
 * Types shared by the audio clock generator.
 * Assumes nothing of its surroundings.
 */
package audio_clock_pkg;
   typedef enum logic [1:0] {
      RESP_OKAY   = 2'h0,
      RESP_SLVERR = 2'h2
   } axi_resp_t;
endpackage : audio_clock_pkg

// file: field_locked_audio_clock_gen.sv
/*
 * Field-locked audio master clock synthesis, bit and left/right clock
 * dividers, crystal forwarding and strap capture, with an AXI4-Lite
 * register slave. Assumes aclk is much faster than the crystal and the
 * returned master clock; all pins are sampled through two flip-flops.
 */
// Decided for this implementation: the AXI4-Lite slave port.
// Notes on behaviour
// - master clock is phase-locked slowly to field rate, fixed samples/field
// - master clock rate set by 18-bit clocks/field and 22-bit increment
// - dividers run from the returned master clock input, tied or external
// - bit clock divides master input, edge chosen by bit phase select
// - left/right clock divides bit clock, edge chosen by lr phase select
// - strap on the left/right pin sampled in reset is only reported as crystal select in status
// - crystal oscillation can be forwarded on the crystal clock output
// - bit clock equals master input over twice (divider plus one)
// - left/right clock equals bit clock over twice the lr divider
// - phase select 0 toggles on falling source edge, 1 on rising
`timescale 1ns/1ns
`include "audio_clock_params.svh"

module field_locked_audio_clock_gen #(
   parameter int ADDR_W = 8
) (
   input  wire logic              aclk,                // 100 MHz clock
   input  wire logic              aresetn,             // sync reset
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,        // write address
   input  wire logic              s_axi_awvalid,       // write addr valid
   output logic                   s_axi_awready,       // write addr ready
   input  wire logic [31:0]       s_axi_wdata,         // write data
   input  wire logic [3:0]        s_axi_wstrb,         // byte enables
   input  wire logic              s_axi_wvalid,        // write data valid
   output logic                   s_axi_wready,        // write data ready
   output logic [1:0]             s_axi_bresp,         // write response
   output logic                   s_axi_bvalid,        // write resp valid
   input  wire logic              s_axi_bready,        // write resp ready
   input  wire logic [ADDR_W-1:0] s_axi_araddr,        // read address
   input  wire logic              s_axi_arvalid,       // read addr valid
   output logic                   s_axi_arready,       // read addr ready
   output logic [31:0]            s_axi_rdata,         // read data
   output logic [1:0]             s_axi_rresp,         // read response
   output logic                   s_axi_rvalid,        // read data valid
   input  wire logic              s_axi_rready,        // read data ready
   input  wire logic              xtal_in,             // crystal reference
   input  wire logic              field_ref,           // field timing ref
   input  wire logic              audio_master_clk_in, // returned mclk
   output logic                   audio_master_clk_out,// synthesized mclk
   output logic                   audio_bit_clk,       // serial bit clock
   input  wire logic              audio_lr_clk_i,      // lr pin level
   output logic                   audio_lr_clk_o,      // lr pin drive
   output logic                   audio_lr_clk_oe_n,   // lr drive, low=on
   output logic                   xtal_clk_out         // forwarded crystal
);

   function automatic logic addr_mapped(input logic [5:0] idx);
      addr_mapped = idx inside {`ACG_IDX_CPF_LO, `ACG_IDX_CPF_MID,
         `ACG_IDX_CPF_HI, `ACG_IDX_NI_LO, `ACG_IDX_NI_MID, `ACG_IDX_NI_HI,
         `ACG_IDX_BDIV, `ACG_IDX_LR_DIV, `ACG_IDX_PHASE, `ACG_IDX_STATUS};
   endfunction : addr_mapped

   // pin synchronisers: stage 1 is read only by stage 2
   // not reset, so the strap reaches the capture while reset is held
   logic [3:0] sync1_reg, sync2_reg, sync3_reg;
   always_ff @(posedge aclk) begin
      sync1_reg <= {audio_lr_clk_i, field_ref, audio_master_clk_in,
                    xtal_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
   end
   wire logic xtal_rise  = sync2_reg[0] & ~sync3_reg[0];
   wire logic mclk_rise  = sync2_reg[1] & ~sync3_reg[1];
   wire logic mclk_fall  = ~sync2_reg[1] & sync3_reg[1];
   wire logic field_rise = sync2_reg[2] & ~sync3_reg[2];

   // registers
   logic [7:0] cpf_lo_reg, cpf_mid_reg, cpf_hi_reg;
   logic [7:0] ni_lo_reg, ni_mid_reg, ni_hi_reg;
   logic [7:0] bdiv_reg, lr_divider_reg, phase_reg;
   logic [7:0] cpf_lo_next, cpf_mid_next, cpf_hi_next;
   logic [7:0] ni_lo_next, ni_mid_next, ni_hi_next;
   logic [7:0] bdiv_next, lr_divider_next, phase_next;
   logic       bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic       xtal_sel_reg, xtal_sel_next;
   logic [`ACG_CORR_W-1:0] corr_reg, corr_next;

   wire logic [5:0] wr_idx = s_axi_awaddr[7:2];
   wire logic [5:0] rd_idx = s_axi_araddr[7:2];
   // address and data are taken together so neither can be orphaned
   wire logic wr_take = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
   wire logic rd_take = s_axi_arvalid & ~rvalid_reg;
   wire logic wr_lane = s_axi_wstrb[0];
   wire logic [7:0] wbyte = s_axi_wdata[7:0];
   wire logic corr_sat = (corr_reg == `ACG_CORR_MAX) |
                         (corr_reg == `ACG_CORR_MIN);

   assign s_axi_awready = wr_take;
   assign s_axi_wready  = wr_take;
   assign s_axi_arready = rd_take;

   always_comb begin
      cpf_lo_next  = cpf_lo_reg;
      cpf_mid_next = cpf_mid_reg;
      cpf_hi_next  = cpf_hi_reg;
      ni_lo_next   = ni_lo_reg;
      ni_mid_next  = ni_mid_reg;
      ni_hi_next   = ni_hi_reg;
      bdiv_next    = bdiv_reg;
      lr_divider_next   = lr_divider_reg;
      phase_next   = phase_reg;
      bvalid_next  = bvalid_reg & ~s_axi_bready;
      bresp_next   = bresp_reg;
      rvalid_next  = rvalid_reg & ~s_axi_rready;
      rresp_next   = rresp_reg;
      rdata_next   = rdata_reg;
      if (wr_take) begin
         bvalid_next = 1'b1;
         bresp_next  = addr_mapped(wr_idx) ? audio_clock_pkg::RESP_OKAY
                                           : audio_clock_pkg::RESP_SLVERR;
         if (wr_lane) begin
            unique case (wr_idx)
               `ACG_IDX_CPF_LO:  cpf_lo_next  = wbyte;
               `ACG_IDX_CPF_MID: cpf_mid_next = wbyte;
               `ACG_IDX_CPF_HI:  cpf_hi_next  = wbyte & `ACG_CPF_HI_MASK;
               `ACG_IDX_NI_LO:   ni_lo_next   = wbyte;
               `ACG_IDX_NI_MID:  ni_mid_next  = wbyte;
               `ACG_IDX_NI_HI:   ni_hi_next   = wbyte & `ACG_NI_HI_MASK;
               `ACG_IDX_BDIV:    bdiv_next    = wbyte & `ACG_DIV_MASK;
               `ACG_IDX_LR_DIV:  lr_divider_next   = wbyte & `ACG_DIV_MASK;
               `ACG_IDX_PHASE:   phase_next   = wbyte & `ACG_PHASE_MASK;
               default: ;
            endcase
         end
      end
      if (rd_take) begin
         rvalid_next = 1'b1;
         rresp_next  = addr_mapped(rd_idx) ? audio_clock_pkg::RESP_OKAY
                                           : audio_clock_pkg::RESP_SLVERR;
         rdata_next  = 32'h0000_0000;
         unique case (rd_idx)
            `ACG_IDX_CPF_LO:  rdata_next[7:0] = cpf_lo_reg;
            `ACG_IDX_CPF_MID: rdata_next[7:0] = cpf_mid_reg;
            `ACG_IDX_CPF_HI:  rdata_next[7:0] = cpf_hi_reg;
            `ACG_IDX_NI_LO:   rdata_next[7:0] = ni_lo_reg;
            `ACG_IDX_NI_MID:  rdata_next[7:0] = ni_mid_reg;
            `ACG_IDX_NI_HI:   rdata_next[7:0] = ni_hi_reg;
            `ACG_IDX_BDIV:    rdata_next[7:0] = bdiv_reg;
            `ACG_IDX_LR_DIV:  rdata_next[7:0] = lr_divider_reg;
            `ACG_IDX_PHASE:   rdata_next[7:0] = phase_reg;
            `ACG_IDX_STATUS: begin
               rdata_next[`ACG_BIT_XTAL_SEL] = xtal_sel_reg;
               rdata_next[`ACG_BIT_CORR_SAT] = corr_sat;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpf_lo_reg  <= `ACG_RESET_BYTE;
         cpf_mid_reg <= `ACG_RESET_BYTE;
         cpf_hi_reg  <= `ACG_RESET_BYTE;
         ni_lo_reg   <= `ACG_RESET_BYTE;
         ni_mid_reg  <= `ACG_RESET_BYTE;
         ni_hi_reg   <= `ACG_RESET_BYTE;
         bdiv_reg    <= `ACG_RESET_BYTE;
         lr_divider_reg   <= `ACG_RESET_BYTE;
         phase_reg   <= `ACG_RESET_BYTE;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= audio_clock_pkg::RESP_OKAY;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= audio_clock_pkg::RESP_OKAY;
         rdata_reg   <= 32'h0000_0000;
      end else begin
         cpf_lo_reg  <= cpf_lo_next;
         cpf_mid_reg <= cpf_mid_next;
         cpf_hi_reg  <= cpf_hi_next;
         ni_lo_reg   <= ni_lo_next;
         ni_mid_reg  <= ni_mid_next;
         ni_hi_reg   <= ni_hi_next;
         bdiv_reg    <= bdiv_next;
         lr_divider_reg   <= lr_divider_next;
         phase_reg   <= phase_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         rvalid_reg  <= rvalid_next;
         rresp_reg   <= rresp_next;
         rdata_reg   <= rdata_next;
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp  = rresp_reg;
   assign s_axi_rdata  = rdata_reg;

   // master clock synthesis: accumulator steps on each crystal rising edge
   wire logic [`ACG_CPF_W-1:0] cpf = {cpf_hi_reg[1:0], cpf_mid_reg,
                                      cpf_lo_reg};
   wire logic [`ACG_NI_W-1:0]  ni  = {ni_hi_reg[5:0], ni_mid_reg,
                                      ni_lo_reg};
   wire logic pll_open = phase_reg[`ACG_BIT_PLL_OPEN];
   logic [`ACG_ACC_W-1:0] acc_reg, acc_next, incr;
   logic [`ACG_CPF_W-1:0] fcnt_reg, fcnt_next;
   logic                  mout_reg, mout_next, xout_reg, xout_next;
   logic                  lr_oe_n_reg, lr_oe_n_next;

   always_comb begin
      // open loop runs at the nominal rate alone
      incr = pll_open ? {1'b0, ni}
                      : {1'b0, ni} + {{(`ACG_ACC_W-`ACG_CORR_W){corr_reg
                        [`ACG_CORR_W-1]}}, corr_reg};
      acc_next  = xtal_rise ? acc_reg + incr : acc_reg;
      mout_next = acc_reg[`ACG_ACC_W-1];
      fcnt_next = fcnt_reg;
      corr_next = corr_reg;
      if (mout_next & ~mout_reg)
         fcnt_next = fcnt_reg + 1'b1;
      // one step per field keeps the loop very slow
      if (field_rise) begin
         fcnt_next = '0;
         if (pll_open)
            corr_next = '0;
         else if (fcnt_reg < cpf && corr_reg != `ACG_CORR_MAX)
            corr_next = corr_reg + 1'b1;
         else if (fcnt_reg > cpf && corr_reg != `ACG_CORR_MIN)
            corr_next = corr_reg - 1'b1;
      end
      xout_next    = sync2_reg[0] & phase_reg[`ACG_BIT_XFWD_EN];
      xtal_sel_next = aresetn ? xtal_sel_reg : sync2_reg[3];
      lr_oe_n_next = 1'b0;
   end

   always_ff @(posedge aclk) begin
      // strap is followed while reset is held, frozen at release
      xtal_sel_reg <= xtal_sel_next;
      if (!aresetn) begin
         acc_reg     <= '0;
         fcnt_reg    <= '0;
         corr_reg    <= '0;
         mout_reg    <= 1'b0;
         xout_reg    <= 1'b0;
         lr_oe_n_reg <= 1'b1;
      end else begin
         acc_reg     <= acc_next;
         fcnt_reg    <= fcnt_next;
         corr_reg    <= corr_next;
         mout_reg    <= mout_next;
         xout_reg    <= xout_next;
         lr_oe_n_reg <= lr_oe_n_next;
      end
   end

   assign audio_master_clk_out = mout_reg;
   assign xtal_clk_out         = xout_reg;
   assign audio_lr_clk_oe_n    = lr_oe_n_reg;

   // dividers run from the returned master clock
   logic [5:0] bcnt_reg, bcnt_next, lcnt_reg, lcnt_next;
   logic       bclk_reg, bclk_next, lrclk_reg, lrclk_next;
   wire logic  bsrc_edge = phase_reg[`ACG_BIT_BPH] ? mclk_rise
                                                   : mclk_fall;
   wire logic  lr_edge = bsrc_edge && bcnt_reg == bdiv_reg[5:0] &&
                         (bclk_reg ^ phase_reg[`ACG_BIT_LR_PHASE]) == 1'b1;

   always_comb begin
      bcnt_next  = bcnt_reg;
      bclk_next  = bclk_reg;
      lcnt_next  = lcnt_reg;
      lrclk_next = lrclk_reg;
      if (bsrc_edge) begin
         if (bcnt_reg == bdiv_reg[5:0]) begin
            bcnt_next = '0;
            bclk_next = ~bclk_reg;
         end else
            bcnt_next = bcnt_reg + 1'b1;
      end
      // zero divider parks the lr clock
      if (lr_edge && lr_divider_reg[5:0] != 6'h00) begin
         if (lcnt_reg == lr_divider_reg[5:0] - 6'h01) begin
            lcnt_next  = '0;
            lrclk_next = ~lrclk_reg;
         end else
            lcnt_next = lcnt_reg + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bcnt_reg  <= '0;
         bclk_reg  <= 1'b0;
         lcnt_reg  <= '0;
         lrclk_reg <= 1'b0;
      end else begin
         bcnt_reg  <= bcnt_next;
         bclk_reg  <= bclk_next;
         lcnt_reg  <= lcnt_next;
         lrclk_reg <= lrclk_next;
      end
   end

   assign audio_bit_clk  = bclk_reg;
   assign audio_lr_clk_o = lrclk_reg;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   a_write_answer: assert property (s_wr_taken |=> s_axi_bvalid)
      else $error("write not answered next cycle");
   a_read_answer: assert property (s_rd_taken ##1 1'b1 |-> s_axi_rvalid
      && s_axi_rresp == (addr_mapped($past(rd_idx)) ? 2'h0 : 2'h2))
      else $error("read answer wrong");
   a_bit_toggle: assert property (bsrc_edge && bcnt_reg == bdiv_reg[5:0]
      && $stable(bdiv_reg) |=> audio_bit_clk != $past(audio_bit_clk))
      else $error("bit clock missed its toggle");
   a_bit_hold: assert property (!bsrc_edge |=> $stable(audio_bit_clk))
      else $error("bit clock moved without source edge");
   a_bit_phase: assert property ($changed(audio_bit_clk) |->
      $past(phase_reg[0] ? mclk_rise : mclk_fall))
      else $error("bit clock on wrong source edge");
   a_lr_hold: assert property (lr_divider_reg[5:0] == 6'h00 &&
      $stable(lr_divider_reg) |=> $stable(audio_lr_clk_o))
      else $error("lr clock moved with zero divider");
   a_lr_source: assert property ($changed(audio_lr_clk_o) |->
      $past(bsrc_edge))
      else $error("lr clock moved off a bit clock edge");
   a_pll_up: assert property (field_rise && !pll_open && fcnt_reg < cpf
      && corr_reg != `ACG_CORR_MAX |=> corr_reg == $past(corr_reg) + 1'b1)
      else $error("loop did not step up");
   a_open_loop: assert property (pll_open |-> incr == {1'b0, ni})
      else $error("open loop not at nominal increment");
   a_xtal_fwd: assert property (!phase_reg[`ACG_BIT_XFWD_EN] ##1
      !phase_reg[`ACG_BIT_XFWD_EN] |-> !xtal_clk_out)
      else $error("crystal forwarded while disabled");
   a_strap_hold: assert property ($stable(xtal_sel_reg) ##1
      !audio_lr_clk_oe_n |-> $stable(xtal_sel_reg))
      else $error("strap value changed outside reset");

endmodule : field_locked_audio_clock_gen

// file: audio_far_side.sv
/*
 * Model of the board and audio converter beside the clock block: returned
 * master clock source and the strap pull on the left/right pin.
 * Assumes the bench clock runs far faster than the clocks made here.
 */
`timescale 1ns/1ns
module audio_far_side (
   input  wire logic aclk,      // bench clock
   input  wire logic use_ext,   // 1 = own oscillator, 0 = looped back
   input  wire logic mclk_out,  // device master clock
   input  wire logic strap,     // pull level on the lr pin
   input  wire logic lr_o,      // device lr drive value
   input  wire logic lr_oe_n,   // device lr drive, low = on
   output logic      mclk_in,   // returned master clock
   output logic      lr_pin     // resolved lr pin level
);
   logic [1:0] cnt = 2'h0;
   logic       ext = 1'b0;

   // external oscillator, period 8 bench cycles
   always @(posedge aclk) begin
      cnt <= cnt + 2'h1;
      if (cnt == 2'h3) begin
         ext <= ~ext;
      end
   end

   assign mclk_in = use_ext ? ext : mclk_out;
   // released pin falls back to the strap resistor
   assign lr_pin = lr_oe_n ? strap : lr_o;
endmodule : audio_far_side

// file: tb_top.sv
/*
 * Self-checking bench for the field-locked audio clock generator.
 * Assumes the design files and the far-side model are compiled first.
 */
`timescale 1ns/1ns
`include "audio_clock_params.svh"
module tb_top;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0]  wstrb = 4'h0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic        xtal_in = 1'b0, field_ref = 1'b0, use_ext = 1'b1;
   logic        strap = 1'b1, mclk_in, mclk_out, bit_clk;
   logic        lr_pin, lr_o, lr_oe_n, xtal_out;
   logic        m_q, m_dir, b_q, b_dir, l_q, l_dir;
   int          fails = 0, checked = 0, xc = 0, fc = 0;

   field_locked_audio_clock_gen dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .xtal_in(xtal_in),
      .field_ref(field_ref), .audio_master_clk_in(mclk_in),
      .audio_master_clk_out(mclk_out), .audio_bit_clk(bit_clk),
      .audio_lr_clk_i(lr_pin), .audio_lr_clk_o(lr_o),
      .audio_lr_clk_oe_n(lr_oe_n), .xtal_clk_out(xtal_out));

   audio_far_side far (.aclk(aclk), .use_ext(use_ext), .mclk_out(mclk_out),
      .strap(strap), .lr_o(lr_o), .lr_oe_n(lr_oe_n), .mclk_in(mclk_in),
      .lr_pin(lr_pin));

   always #5 aclk = ~aclk;

   // crystal period 6 cycles, field period 960 cycles
   always @(posedge aclk) begin
      xc <= (xc == 2) ? 0 : xc + 1;
      fc <= (fc == 479) ? 0 : fc + 1;
      if (xc == 2) begin
         xtal_in <= ~xtal_in;
      end
      if (fc == 479) begin
         field_ref <= ~field_ref;
      end
   end

   // direction of the source edge behind each derived clock toggle
   always @(posedge aclk) begin
      if (mclk_in !== m_q) m_dir = mclk_in;
      m_q = mclk_in;
      if (bit_clk !== b_q) b_dir = m_dir;
      if (lr_o !== l_q) l_dir = bit_clk;
      b_q = bit_clk;
      l_q = lr_o;
   end

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   function automatic logic [7:0] adr(input logic [5:0] i);
      return {i, 2'b00};
   endfunction : adr

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      logic       hit;
      logic [1:0] resp;
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= 4'hF;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      // ready sampled settled, just before the edge that takes it
      do begin
         #1;
         hit = awready;
         @(posedge aclk);
      end while (hit !== 1'b1);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      do begin
         #1;
         hit  = bvalid;
         resp = bresp;
         @(posedge aclk);
      end while (hit !== 1'b1);
      bready <= 1'b0;
      check("bresp", {30'h0, er}, {30'h0, resp});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      logic        hit;
      logic [31:0] data;
      logic [1:0]  resp;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         #1;
         hit = arready;
         @(posedge aclk);
      end while (hit !== 1'b1);
      arvalid <= 1'b0;
      do begin
         #1;
         hit  = rvalid;
         data = rdata;
         resp = rresp;
         @(posedge aclk);
      end while (hit !== 1'b1);
      rready <= 1'b0;
      check("rdata", ed, data);
      check("rresp", {30'h0, er}, {30'h0, resp});
   endtask : rd

   function automatic logic pick(input int s);
      return (s == 0) ? mclk_out : (s == 1) ? bit_clk : lr_o;
   endfunction : pick

   // fall-to-fall period in bench cycles, bounded wait
   task automatic period(input int s, output int p);
      int n;
      n = 0;
      p = 0;
      while (pick(s) !== 1'b1 && n < 4000) begin @(posedge aclk); n++; end
      while (pick(s) !== 1'b0 && n < 4000) begin @(posedge aclk); n++; end
      while (pick(s) !== 1'b1 && n < 4000) begin @(posedge aclk); n++; p++; end
      while (pick(s) !== 1'b0 && n < 4000) begin @(posedge aclk); n++; p++; end
   endtask : period

   task automatic do_reset(input logic s);
      @(posedge aclk);
      strap   <= s;
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      check("oe_n in reset", 32'h1, {31'h0, lr_oe_n});
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      check("oe_n after", 32'h0, {31'h0, lr_oe_n});
      rd(adr(`ACG_IDX_STATUS), {31'h0, s}, 2'h0);
      $display("test reset strap %0d done", s);
   endtask : do_reset

   task automatic t_regs;
      logic [5:0] idx [9];
      logic [7:0] msk [9];
      idx = '{`ACG_IDX_CPF_LO, `ACG_IDX_CPF_MID, `ACG_IDX_CPF_HI,
              `ACG_IDX_NI_LO, `ACG_IDX_NI_MID, `ACG_IDX_NI_HI,
              `ACG_IDX_BDIV, `ACG_IDX_LR_DIV, `ACG_IDX_PHASE};
      msk = '{8'hFF, 8'hFF, `ACG_CPF_HI_MASK, 8'hFF, 8'hFF, `ACG_NI_HI_MASK,
              `ACG_DIV_MASK, `ACG_DIV_MASK, `ACG_PHASE_MASK};
      for (int i = 0; i < 9; i++) begin
         rd(adr(idx[i]), 32'h0, 2'h0);
         wr(adr(idx[i]), 32'hFF, 2'h0);
         rd(adr(idx[i]), {24'h0, msk[i]}, 2'h0);
      end
      wr(8'h00, 32'h5A, 2'h2);
      rd(8'h00, 32'h0, 2'h2);
      $display("test registers done");
   endtask : t_regs

   // lr=0 runs the bit clock sweep, lr=1 the lr clock sweep
   task automatic t_div(input bit lr);
      int p;
      int d;
      for (int i = 0; i < 4; i++) begin
         d = i[1] ? 2 : 1;
         wr(adr(`ACG_IDX_BDIV), lr ? 32'h0 : d - 1, 2'h0);
         wr(adr(`ACG_IDX_LR_DIV), lr ? d : 32'h1, 2'h0);
         wr(adr(`ACG_IDX_PHASE), lr ? {i[0], 1'b1} : {1'b1, i[0]}, 2'h0);
         period(lr ? 2 : 1, p);
         period(lr ? 2 : 1, p);
         check("period", lr ? 32 * d : 16 * d, p);
         if (lr) check("lr edge", i[0], l_dir);
         else check("bit edge", i[0], b_dir);
      end
      $display("test divider %0d done", lr);
   endtask : t_div

   task automatic t_mclk;
      int p;
      @(posedge aclk);
      use_ext <= 1'b0;
      // whole accumulator range every 4 crystal periods
      wr(adr(`ACG_IDX_NI_LO), 32'h0, 2'h0);
      wr(adr(`ACG_IDX_NI_MID), 32'h0, 2'h0);
      wr(adr(`ACG_IDX_NI_HI), 32'h20, 2'h0);
      wr(adr(`ACG_IDX_PHASE), 32'h9, 2'h0);
      wr(adr(`ACG_IDX_BDIV), 32'h0, 2'h0);
      repeat (1100) @(posedge aclk);
      period(0, p);
      check("mclk period", 32'd24, p);
      period(1, p);
      check("looped bit period", 32'd48, p);
      $display("test master clock done");
   endtask : t_mclk

   task automatic t_xtal;
      int n;
      logic pv;
      for (int e = 1; e >= 0; e--) begin
         wr(adr(`ACG_IDX_PHASE), e ? 32'h11 : 32'h01, 2'h0);
         repeat (4) @(posedge aclk);
         n = 0;
         pv = xtal_out;
         repeat (60) begin
            @(posedge aclk);
            if (xtal_out !== pv) n++;
            pv = xtal_out;
         end
         check("xtal toggles", e ? 32'd20 : 32'd0, n);
         check("xtal level", e ? {31'h0, pv} : 32'h0, {31'h0, xtal_out});
      end
      $display("test crystal forward done");
   endtask : t_xtal

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   initial begin
      #500000;
      fails++;
      print_verdict();
   end

   initial begin
      do_reset(1'b1);
      t_regs();
      t_div(1'b0);
      t_div(1'b1);
      t_mclk();
      t_xtal();
      do_reset(1'b0);
      print_verdict();
   end
endmodule : tb_top
